/* logic/clk_pwr_ctrl.v */
// Purpose: clock source selection, PLL control, gating, dividers and power modes
// Assumes: oscillators and PLLs are analog macros driven by these control outputs
// Notes: registers on Avalon-MM, one wait state per access
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "clk_pwr_defs.vh"

module clk_pwr_ctrl #(
  parameter NPERIPH   = 16,
  parameter NPDIV     = 3,
  parameter NWAKE     = 8,
  parameter SETTLE_CY = `PLL_SETTLE_US * `CLK_MHZ
) (
  input  wire                mclk,
  input  wire                srst,
  input  wire [7:0]          address,
  input  wire                read,
  input  wire                write,
  input  wire [31:0]         writedata,
  input  wire [3:0]          byteenable,
  output reg  [31:0]         readdata,
  output reg                 waitrequest,
  input  wire                sys_pll_lock,
  input  wire                usb_pll_lock,
  input  wire [NWAKE-1:0]    wake_gpio,
  input  wire                wdt_irq,
  input  wire                usb_irq,
  input  wire                periph_irq,
  input  wire                wakeup_pin,
  output reg  [1:0]          main_sel_q,
  output reg                 main_gate_q,
  output reg                 sys_pll_src_q,
  output reg                 sys_pll_src_gate_q,
  output reg  [4:0]          sys_pll_msel_q,
  output reg  [1:0]          sys_pll_psel_q,
  output reg                 sys_pll_pd_q,
  output reg                 sys_pll_bypass_q,
  output reg  [4:0]          usb_pll_msel_q,
  output reg  [1:0]          usb_pll_psel_q,
  output reg                 usb_pll_pd_q,
  output reg                 usb_pll_bypass_q,
  output reg                 wdt_sel_q,
  output reg                 wdt_gate_q,
  output reg  [1:0]          clock_output_pin_sel_q,
  output reg                 clock_output_pin_gate_q,
  output reg                 cpu_clk_en_q,
  output reg  [NPERIPH-1:0]  periph_clk_en_q,
  output reg  [NPDIV-1:0]    periph_div_tick_q,
  output reg                 internal_rc_oscillator_en_q,
  output reg                 sys_osc_en_q,
  output reg                 watchdog_oscillator_en_q,
  output reg                 brownout_detector_en_q,
  output reg                 analog_pd_q,
  output reg                 flash_standby_q,
  output reg                 flash_pd_q,
  output reg                 core_power_off_q
);

  // ==========================================================
  // power states
  localparam [2:0] ST_ACTIVE = 3'h0;
  localparam [2:0] ST_SLEEP  = 3'h1;
  localparam [2:0] ST_DSLEEP = 3'h2;
  localparam [2:0] ST_PDOWN  = 3'h3;
  localparam [2:0] ST_DPD    = 3'h4;

  localparam [31:0] SETTLE_W = SETTLE_CY;
  localparam [7:0]  PDIV_END = `OFS_PERIPH_DIV0 + 4 * NPDIV;   // first offset past the divider block

  // ==========================================================
  // software-visible state
  reg  [1:0]         main_req_q;
  reg                pll_src_req_q;
  reg  [8:0]         sys_ctrl_q;
  reg  [8:0]         usb_ctrl_q;
  reg                wdt_req_q;
  reg  [1:0]         cko_req_q;
  reg  [7:0]         cpu_div_q;
  reg  [NPERIPH-1:0] gate_q;
  reg  [8*NPDIV-1:0] pdiv_q;
  reg                wdo_keep_q;
  reg                bod_keep_q;
  reg                dpd_lock_q;
  reg  [2:0]         state_q;
  reg  [2:0]         state_d;
  reg                woke_q;
  reg  [31:0]        sys_settle_q;
  reg  [31:0]        usb_settle_q;
  reg                enter_req;
  reg  [1:0]         enter_mode;
  reg  [31:0]        rd_d;
  reg  [7:0]         cpu_cnt_q;

  wire acc      = (read | write) & waitrequest;
  wire wr_take  = write & ~waitrequest;
  wire low_pwr  = (state_q != ST_ACTIVE);
  wire deep     = (state_q == ST_DSLEEP) | (state_q == ST_PDOWN);

  // ==========================================================
  // pin synchronisers, three stages, change once stages two and three agree
  reg [NWAKE+4:0] pin_s1_q;
  reg [NWAKE+4:0] pin_s2_q;
  reg [NWAKE+4:0] pin_s3_q;
  reg [NWAKE+4:0] pin_q;
  wire [NWAKE+4:0] pin_raw = {wakeup_pin, sys_pll_lock, usb_pll_lock, wdt_irq, usb_irq, wake_gpio};

  always @(posedge mclk) begin
    if (srst) begin
      pin_s1_q <= {(NWAKE+5){1'b0}};
      pin_s2_q <= {(NWAKE+5){1'b0}};
      pin_s3_q <= {(NWAKE+5){1'b0}};
      pin_q    <= {(NWAKE+5){1'b0}};
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end
  end

  wire sys_lock_s = pin_q[NWAKE+3];
  wire usb_lock_s = pin_q[NWAKE+2];
  wire wdt_irq_s  = pin_q[NWAKE+1];
  wire usb_irq_s  = pin_q[NWAKE];
  wire gpio_wk_s  = |pin_q[NWAKE-1:0];
  wire wkpin_s    = pin_q[NWAKE+4];

  // ==========================================================
  // glitch-free muxes: gate off, hold quiet, switch select, gate on
  wire [7:0] mux_req = {2'b00, cko_req_q, 1'b0, wdt_req_q, main_req_q};
  wire [3:0] mux_stop;
  reg  [7:0] mux_sel_q;
  reg  [3:0] mux_gate_q;
  reg  [15:0] mux_cnt_q;
  assign mux_stop[0] = low_pwr;
  assign mux_stop[1] = (state_q == ST_PDOWN) | (state_q == ST_DPD) |
                       ((state_q == ST_DSLEEP) & wdt_sel_q & ~wdo_keep_q);
  assign mux_stop[2] = deep | (state_q == ST_DPD);
  assign mux_stop[3] = 1'b1;

  genvar m;
  generate
    for (m = 0; m < 3; m = m + 1) begin : g_mux
      always @(posedge mclk) begin
        if (srst) begin
          mux_sel_q[2*m+1:2*m]  <= 2'h0;
          mux_gate_q[m]         <= 1'b1;
          mux_cnt_q[4*m+3:4*m]  <= 4'h0;
        end else if (mux_sel_q[2*m+1:2*m] != mux_req[2*m+1:2*m]) begin
          mux_gate_q[m] <= 1'b0;
          if (!mux_gate_q[m] && mux_cnt_q[4*m+3:4*m] == `MUX_QUIET_CYC) begin
            mux_sel_q[2*m+1:2*m] <= mux_req[2*m+1:2*m];
            mux_cnt_q[4*m+3:4*m] <= 4'h0;
          end else if (!mux_gate_q[m]) begin
            mux_cnt_q[4*m+3:4*m] <= mux_cnt_q[4*m+3:4*m] + 4'h1;
          end
        end else begin
          mux_cnt_q[4*m+3:4*m] <= 4'h0;
          mux_gate_q[m] <= ~mux_stop[m];
        end
      end
    end
  endgenerate

  always @(posedge mclk) begin
    mux_sel_q[7:6] <= 2'h0;
    mux_gate_q[3]  <= 1'b0;
    mux_cnt_q[15:12] <= 4'h0;
  end

  // ==========================================================
  // pll source mux: same quiet switch, one bit wide
  reg [3:0] src_cnt_q;
  always @(posedge mclk) begin
    if (srst) begin
      sys_pll_src_q      <= 1'b0;
      sys_pll_src_gate_q <= 1'b1;
      src_cnt_q          <= 4'h0;
    end else if (sys_pll_src_q != pll_src_req_q) begin
      sys_pll_src_gate_q <= 1'b0;
      if (!sys_pll_src_gate_q && src_cnt_q == `MUX_QUIET_CYC) begin
        sys_pll_src_q <= pll_src_req_q;
        src_cnt_q     <= 4'h0;
      end else if (!sys_pll_src_gate_q) begin
        src_cnt_q <= src_cnt_q + 4'h1;
      end
    end else begin
      src_cnt_q          <= 4'h0;
      sys_pll_src_gate_q <= ~(deep | (state_q == ST_DPD));
    end
  end

  // ==========================================================
  // mux and pll outputs
  always @(posedge mclk) begin
    if (srst) begin
      main_sel_q              <= `MAIN_SEL_RST;
      main_gate_q             <= 1'b1;
      wdt_sel_q               <= 1'b0;
      wdt_gate_q              <= 1'b1;
      clock_output_pin_sel_q  <= 2'h0;
      clock_output_pin_gate_q <= 1'b1;
      sys_pll_msel_q          <= 5'h00;
      sys_pll_psel_q          <= 2'h0;
      sys_pll_pd_q            <= 1'b1;
      sys_pll_bypass_q        <= 1'b1;
      usb_pll_msel_q          <= 5'h00;
      usb_pll_psel_q          <= 2'h0;
      usb_pll_pd_q            <= 1'b1;
      usb_pll_bypass_q        <= 1'b1;
    end else begin
      main_sel_q              <= mux_sel_q[1:0];
      main_gate_q             <= mux_gate_q[0];
      wdt_sel_q               <= mux_sel_q[2];
      wdt_gate_q              <= mux_gate_q[1];
      clock_output_pin_sel_q  <= mux_sel_q[5:4];
      clock_output_pin_gate_q <= mux_gate_q[2];
      // identical field layout for both plls
      sys_pll_msel_q   <= sys_ctrl_q[`PLL_MSEL_LSB+4:`PLL_MSEL_LSB];
      sys_pll_psel_q   <= sys_ctrl_q[`PLL_PSEL_LSB+1:`PLL_PSEL_LSB];
      sys_pll_pd_q     <= sys_ctrl_q[`PLL_PD_BIT] | deep | (state_q == ST_DPD);
      sys_pll_bypass_q <= sys_ctrl_q[`PLL_BYP_BIT];
      usb_pll_msel_q   <= usb_ctrl_q[`PLL_MSEL_LSB+4:`PLL_MSEL_LSB];
      usb_pll_psel_q   <= usb_ctrl_q[`PLL_PSEL_LSB+1:`PLL_PSEL_LSB];
      usb_pll_pd_q     <= usb_ctrl_q[`PLL_PD_BIT] | deep | (state_q == ST_DPD);
      usb_pll_bypass_q <= usb_ctrl_q[`PLL_BYP_BIT];
    end
  end

  // ==========================================================
  // pll settle timers, restart whenever the pll is powered down
  always @(posedge mclk) begin
    if (srst) begin
      sys_settle_q <= 32'h0;
      usb_settle_q <= 32'h0;
    end else begin
      if (sys_pll_pd_q)
        sys_settle_q <= 32'h0;
      else if (sys_settle_q != SETTLE_W)
        sys_settle_q <= sys_settle_q + 32'h1;
      if (usb_pll_pd_q)
        usb_settle_q <= 32'h0;
      else if (usb_settle_q != SETTLE_W)
        usb_settle_q <= usb_settle_q + 32'h1;
    end
  end

  wire sys_locked = sys_lock_s & (sys_settle_q == SETTLE_W);
  wire usb_locked = usb_lock_s & (usb_settle_q == SETTLE_W);

  // ==========================================================
  // processor clock divider, zero stops the core clock
  always @(posedge mclk) begin
    if (srst) begin
      cpu_cnt_q    <= 8'h00;
      cpu_clk_en_q <= 1'b0;
    end else begin
      if (cpu_cnt_q + 8'h01 >= cpu_div_q)
        cpu_cnt_q <= 8'h00;
      else
        cpu_cnt_q <= cpu_cnt_q + 8'h01;
      cpu_clk_en_q <= (cpu_div_q != 8'h00) && (cpu_cnt_q == 8'h00) &&
                      !low_pwr && main_gate_q;
    end
  end

  // ==========================================================
  // peripheral dividers, independent of the processor divider
  reg [8*NPDIV-1:0] pcnt_q;
  genvar d;
  generate
    for (d = 0; d < NPDIV; d = d + 1) begin : g_pdiv
      always @(posedge mclk) begin
        if (srst) begin
          pcnt_q[8*d+7:8*d]    <= 8'h00;
          periph_div_tick_q[d] <= 1'b0;
        end else begin
          if (pcnt_q[8*d+7:8*d] + 8'h01 >= pdiv_q[8*d+7:8*d])
            pcnt_q[8*d+7:8*d] <= 8'h00;
          else
            pcnt_q[8*d+7:8*d] <= pcnt_q[8*d+7:8*d] + 8'h01;
          periph_div_tick_q[d] <= (pdiv_q[8*d+7:8*d] != 8'h00) &&
                                  (pcnt_q[8*d+7:8*d] == 8'h00) && !deep &&
                                  (state_q != ST_DPD);
        end
      end
    end
  endgenerate

  // ==========================================================
  // peripheral gates and analog power controls per mode
  always @(posedge mclk) begin
    if (srst) begin
      periph_clk_en_q             <= {NPERIPH{1'b1}};
      internal_rc_oscillator_en_q <= 1'b1;
      sys_osc_en_q                <= 1'b0;
      watchdog_oscillator_en_q    <= 1'b0;
      brownout_detector_en_q      <= 1'b1;
      analog_pd_q                 <= 1'b0;
      flash_standby_q             <= 1'b0;
      flash_pd_q                  <= 1'b0;
      core_power_off_q            <= 1'b0;
    end else begin
      // sleep keeps peripheral clocks; deeper modes stop them
      periph_clk_en_q <= (state_q == ST_ACTIVE || state_q == ST_SLEEP) ?
                         gate_q : {NPERIPH{1'b0}};
      case (state_q)
        ST_ACTIVE, ST_SLEEP: begin
          internal_rc_oscillator_en_q <= 1'b1;
          sys_osc_en_q                <= 1'b1;
          watchdog_oscillator_en_q    <= 1'b1;
          brownout_detector_en_q      <= 1'b1;
          analog_pd_q                 <= 1'b0;
          flash_standby_q             <= 1'b0;
          flash_pd_q                  <= 1'b0;
          core_power_off_q            <= 1'b0;
        end
        ST_DSLEEP: begin
          internal_rc_oscillator_en_q <= ~wdt_sel_q;
          sys_osc_en_q                <= 1'b0;
          watchdog_oscillator_en_q    <= wdo_keep_q;
          brownout_detector_en_q      <= bod_keep_q;
          analog_pd_q                 <= 1'b1;
          flash_standby_q             <= 1'b1;
          flash_pd_q                  <= 1'b0;
          core_power_off_q            <= 1'b0;
        end
        ST_PDOWN: begin
          internal_rc_oscillator_en_q <= 1'b0;
          sys_osc_en_q                <= 1'b0;
          watchdog_oscillator_en_q    <= wdo_keep_q;
          brownout_detector_en_q      <= bod_keep_q;
          analog_pd_q                 <= 1'b1;
          flash_standby_q             <= 1'b0;
          flash_pd_q                  <= 1'b1;
          core_power_off_q            <= 1'b0;
        end
        default: begin
          internal_rc_oscillator_en_q <= 1'b0;
          sys_osc_en_q                <= 1'b0;
          watchdog_oscillator_en_q    <= 1'b0;
          brownout_detector_en_q      <= 1'b0;
          analog_pd_q                 <= 1'b1;
          flash_standby_q             <= 1'b0;
          flash_pd_q                  <= 1'b1;
          core_power_off_q            <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // power mode state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE:
        if (enter_req) begin
          case (enter_mode)
            2'h0:    state_d = ST_SLEEP;
            2'h1:    state_d = ST_DSLEEP;
            2'h2:    state_d = ST_PDOWN;
            default: state_d = dpd_lock_q ? ST_ACTIVE : ST_DPD;
          endcase
        end
      ST_SLEEP:
        if (periph_irq | wdt_irq_s | usb_irq_s | gpio_wk_s)
          state_d = ST_ACTIVE;
      ST_DSLEEP, ST_PDOWN:
        if (gpio_wk_s | wdt_irq_s | usb_irq_s)
          state_d = ST_ACTIVE;
      ST_DPD:
        if (!wkpin_s)
          state_d = ST_ACTIVE;
      default:
        state_d = ST_ACTIVE;
    endcase
  end

  wire dpd_exit = (state_q == ST_DPD) && (state_d == ST_ACTIVE);

  always @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_ACTIVE;
      woke_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (low_pwr && state_d == ST_ACTIVE)
        woke_q <= 1'b1;
      else if (wr_take && address == `OFS_PWR_STATUS && byteenable[0] && writedata[3])
        woke_q <= 1'b0;
    end
  end

  // ==========================================================
  // avalon slave: one wait state, access completes when waitrequest is low
  always @* begin
    enter_req  = wr_take && (address == `OFS_PWR_ENTER) && byteenable[0];
    enter_mode = writedata[1:0];
    rd_d       = 32'h0;
    if (address == `OFS_MAIN_SEL)
      rd_d[1:0] = main_req_q;
    else if (address == `OFS_SYSPLL_SRC)
      rd_d[0] = pll_src_req_q;
    else if (address == `OFS_SYSPLL_CTRL)
      rd_d[8:0] = sys_ctrl_q;
    else if (address == `OFS_USBPLL_CTRL)
      rd_d[8:0] = usb_ctrl_q;
    else if (address == `OFS_PLL_STATUS)
      rd_d[1:0] = {usb_locked, sys_locked};
    else if (address == `OFS_WDT_SEL)
      rd_d[0] = wdt_req_q;
    else if (address == `OFS_CLOCK_OUTPUT_PIN_SEL)
      rd_d[1:0] = cko_req_q;
    else if (address == `OFS_CPU_DIV)
      rd_d[7:0] = cpu_div_q;
    else if (address == `OFS_PERIPH_GATE)
      rd_d[NPERIPH-1:0] = gate_q;
    else if (address >= `OFS_PERIPH_DIV0 && address < PDIV_END && address[1:0] == 2'h0)
      rd_d[7:0] = pdiv_q[8*((address-`OFS_PERIPH_DIV0)>>2) +: 8];
    else if (address == `OFS_PWR_CFG)
      rd_d[2:0] = {dpd_lock_q, bod_keep_q, wdo_keep_q};
    else if (address == `OFS_PWR_STATUS)
      rd_d[3:0] = {woke_q, state_q};
  end

  integer k;
  always @(posedge mclk) begin
    if (srst || dpd_exit) begin
      waitrequest   <= 1'b1;
      readdata      <= 32'h0;
      main_req_q    <= `MAIN_SEL_RST;
      pll_src_req_q <= 1'b0;
      sys_ctrl_q    <= `PLL_CTRL_RST;
      usb_ctrl_q    <= `PLL_CTRL_RST;
      wdt_req_q     <= 1'b0;
      cko_req_q     <= 2'h0;
      cpu_div_q     <= `CPU_DIV_RST;
      gate_q        <= {NPERIPH{1'b1}};
      pdiv_q        <= {NPDIV{`PDIV_RST}};
      wdo_keep_q    <= 1'b0;
      bod_keep_q    <= 1'b0;
      dpd_lock_q    <= dpd_exit & dpd_lock_q;
    end else begin
      waitrequest <= ~acc;
      if (acc)
        readdata <= read ? rd_d : 32'h0;
      if (wr_take && byteenable[0]) begin
        if (address == `OFS_MAIN_SEL)
          main_req_q <= writedata[1:0];
        else if (address == `OFS_SYSPLL_SRC)
          pll_src_req_q <= writedata[0];
        else if (address == `OFS_SYSPLL_CTRL)
          sys_ctrl_q <= byteenable[1] ? writedata[8:0] : {sys_ctrl_q[8], writedata[7:0]};
        else if (address == `OFS_USBPLL_CTRL)
          usb_ctrl_q <= byteenable[1] ? writedata[8:0] : {usb_ctrl_q[8], writedata[7:0]};
        else if (address == `OFS_WDT_SEL)
          wdt_req_q <= writedata[0];
        else if (address == `OFS_CLOCK_OUTPUT_PIN_SEL)
          cko_req_q <= writedata[1:0];
        else if (address == `OFS_CPU_DIV)
          cpu_div_q <= writedata[7:0];
        else if (address == `OFS_PWR_CFG) begin
          wdo_keep_q <= writedata[`PWR_WDO_KEEP_BIT];
          bod_keep_q <= writedata[`PWR_BOD_KEEP_BIT];
          dpd_lock_q <= dpd_lock_q | writedata[`PWR_DPD_LOCK_BIT];
        end
      end
      if (wr_take && address == `OFS_PERIPH_GATE)
        for (k = 0; k < NPERIPH; k = k + 1)
          if (byteenable[k/8])
            gate_q[k] <= writedata[k];
      if (wr_take && byteenable[0])
        for (k = 0; k < NPDIV; k = k + 1)
          if (address == `OFS_PERIPH_DIV0 + 4 * k)
            pdiv_q[8*k +: 8] <= writedata[7:0];
    end
  end

endmodule

/* logic/clk_pwr_defs.vh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit Avalon-MM word addressing by byte address, 100 MHz mclk
// Notes: included by the clock and power control block only
// How it works
// - after reset or deep power-down wake, main clock comes from internal RC oscillator
// - internal RC oscillator selectable as watchdog clock and system PLL input
// - crystal oscillator selectable as processor clock, direct or through system PLL
// - watchdog oscillator selectable as processor clock, watchdog clock, clock output
// - two identical PLLs: system clock and 48 MHz USB clock
// - each PLL feedback multiplier accepts any integer 1 through 32
// - PLL post divider 2, 4, 8 or 16, giving 50 percent duty
// - after reset each PLL is powered down and bypassed until software enables it
// - clock output mux picks RC, crystal, watchdog oscillator or main clock
// - four reduced-power modes: sleep, deep-sleep, power-down, deep power-down
// - one clock gate bit per peripheral stops unused peripheral clocks
// - programmable processor clock divider plus independent peripheral dividers
// - sleep gates core clock; leaving sleep only ungates it
// - sleep keeps peripheral clocks running; reset or interrupt resumes core
// - deep-sleep stops all but RC oscillator, gated unless it clocks watchdog
// - deep-sleep shuts analog, flash standby, optionally keeps watchdog osc and brownout
// - deep-sleep and power-down wake on reset, pins, watchdog or USB interrupt
// - power-down stops all but optional watchdog osc and brownout; analog and flash off
// - deep power-down removes power except wake pin logic; only that pin wakes
// - lock bit, once set, blocks deep power-down entry
`ifndef CLK_PWR_DEFS_VH
`define CLK_PWR_DEFS_VH

// ==========================================================
// register byte offsets
`define OFS_MAIN_SEL     8'h00
`define OFS_SYSPLL_SRC   8'h04
`define OFS_SYSPLL_CTRL  8'h08
`define OFS_USBPLL_CTRL  8'h0c
`define OFS_PLL_STATUS   8'h10
`define OFS_WDT_SEL      8'h14
`define OFS_CLOCK_OUTPUT_PIN_SEL   8'h18
`define OFS_CPU_DIV      8'h1c
`define OFS_PERIPH_GATE  8'h20
`define OFS_PERIPH_DIV0  8'h24
`define OFS_PWR_CFG      8'h30
`define OFS_PWR_ENTER    8'h34
`define OFS_PWR_STATUS   8'h38

// ==========================================================
// field positions in pll control
`define PLL_MSEL_LSB     0
`define PLL_PSEL_LSB     5
`define PLL_PD_BIT       7
`define PLL_BYP_BIT      8

// field positions in power config
`define PWR_WDO_KEEP_BIT 0
`define PWR_BOD_KEEP_BIT 1
`define PWR_DPD_LOCK_BIT 2

// ==========================================================
// reset values
`define MAIN_SEL_RST     2'h0
`define PLL_CTRL_RST     9'h180
`define CPU_DIV_RST      8'h01
`define PDIV_RST         8'h01

// ==========================================================
// timing
`define PLL_SETTLE_US    100
`define CLK_MHZ          100
`define MUX_QUIET_CYC    4'h4

`endif

/* tb/clk_pwr_ctrl_sva.sv */
// Purpose: port checker for the clock and power control block
// Assumes: wake inputs stay low while a low-power mode settles
// Notes: bound from the bench top file
`timescale 1ns/1ns
module clk_pwr_ctrl_sva (
  input wire        mclk, srst, read, write, waitrequest, main_gate_q, cpu_clk_en_q,
  input wire        sys_pll_pd_q, sys_pll_bypass_q, sys_osc_en_q, flash_standby_q,
  input wire        flash_pd_q, core_power_off_q,
  input wire [7:0]  address,
  input wire [31:0] writedata,
  input wire [1:0]  main_sel_q, sys_pll_psel_q,
  input wire [4:0]  sys_pll_msel_q
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================
  // write decode and lock tracking
  wire wr = write & ~waitrequest;
  reg  lock_q;
  always @(posedge mclk) lock_q <= srst ? 1'b0 : lock_q | (wr && address == 8'h30 && writedata[2]);
  // ==========================================
  // properties
  chk_wait_one:
    assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
  chk_req_answer:
    assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  chk_reset_rc:
    assert property (disable iff (1'b0) srst |=> main_sel_q == 2'h0 && sys_pll_pd_q && sys_pll_bypass_q)
      else $error("reset state wrong");
  chk_pll_fields:
    assert property (wr && address == 8'h08 |=> ##1 {sys_pll_bypass_q, sys_pll_pd_q, sys_pll_psel_q,
      sys_pll_msel_q} == $past(writedata[8:0], 2)) else $error("pll fields wrong");
  chk_sleep_core:
    assert property (wr && address == 8'h34 && writedata[1:0] == 2'h0 |=> ##2 !cpu_clk_en_q [*3])
      else $error("core clock runs in sleep");
  chk_dsleep_out:
    assert property (wr && address == 8'h34 && writedata[1:0] == 2'h1 |=> ##2 flash_standby_q && !sys_osc_en_q)
      else $error("deep sleep levels wrong");
  chk_pdown_out:
    assert property (wr && address == 8'h34 && writedata[1:0] == 2'h2 |=> ##2 flash_pd_q && !sys_osc_en_q)
      else $error("power down levels wrong");
  chk_mux_quiet:
    assert property ($changed(main_sel_q) |-> !main_gate_q && !$past(main_gate_q)) else $error("ungated switch");
  chk_dpd_lock:
    assert property (lock_q |-> !core_power_off_q) else $error("locked device powered off");
endmodule

/* tb/test_clk_pwr_ctrl.sv */
// Purpose: self-checking bench for the clock and power control block
// Assumes: settle count shortened to 20 cycles
// Notes: register mirror m holds expected values
`timescale 1ns/1ns
module test_clk_pwr_ctrl;
  reg mclk = 0, srst = 1, read = 0, write = 0, wdt_irq = 0, usb_irq = 0, periph_irq = 0, wakeup_pin = 1, lk = 0;
  reg [7:0] address = 8'h00, wake_gpio = 8'h00;
  reg [31:0] writedata = 32'h0, rdv, x = 32'h0000f7c4, d;
  int fail_count = 0, n_compared = 0, m[int], md[4] = '{0, 1, 2, 2};
  wire [31:0] readdata;
  wire [1:0] main_sel_q, sys_pll_psel_q, usb_pll_psel_q, clock_output_pin_sel_q;
  wire [4:0] sys_pll_msel_q, usb_pll_msel_q;
  wire [15:0] periph_clk_en_q;
  wire [2:0] periph_div_tick_q;
  wire waitrequest, main_gate_q, sys_pll_src_q, sys_pll_src_gate_q, sys_pll_pd_q, sys_pll_bypass_q, usb_pll_pd_q,
    usb_pll_bypass_q, wdt_sel_q, wdt_gate_q, clock_output_pin_gate_q, cpu_clk_en_q, internal_rc_oscillator_en_q,
    sys_osc_en_q, watchdog_oscillator_en_q, brownout_detector_en_q, analog_pd_q, flash_standby_q, flash_pd_q,
    core_power_off_q;
  clk_pwr_ctrl #(.SETTLE_CY(20)) i_clk_pwr_ctrl (.*, .byteenable(4'hf), .sys_pll_lock(lk), .usb_pll_lock(lk));
  // ==========================================
  // helpers
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int n = 0;
    @(posedge mclk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= dv;
    do @(posedge mclk); while (waitrequest !== 1'b0 && ++n < 99);
    if (n >= 99) fail_count++;
    rdv = readdata;
    read <= 0;
    write <= 0;
    if (w) m[a] = dv;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 0;
    acc(0, 8'h00, 0);
    chk("main_sel", 0, rdv);
    acc(0, 8'h08, 0);
    chk("pll_ctrl", 32'h180, rdv);
    acc(0, 8'h20, 0);
    chk("gates", 32'hffff, rdv);
    acc(0, 8'h3c, 0);
    chk("unmapped", 0, rdv);
    chk("cpu_tick", 1, cpu_clk_en_q);
    chk("pdiv_tick", 32'h7, periph_div_tick_q);
    for (int i = 0; i < 8; i++) begin
      d = (rnd() & 32'h19f) | (i[1:0] << 5);
      acc(1, i[2] ? 8'h0c : 8'h08, d);
      acc(0, i[2] ? 8'h0c : 8'h08, 0);
      chk("pll_rd", m[i[2] ? 8'h0c : 8'h08], rdv);
      chk("usb_pll", d | {9{!i[2]}}, {usb_pll_bypass_q, usb_pll_pd_q, usb_pll_psel_q, usb_pll_msel_q} | {9{!i[2]}});
    end
    lk <= 1;
    acc(1, 8'h08, 0);
    acc(0, 8'h10, 0);
    chk("lock_early", 0, rdv[0]);
    repeat (30) @(posedge mclk);
    acc(0, 8'h10, 0);
    chk("lock", 1, rdv[0]);
    acc(1, 8'h04, 1);
    for (int v = 3; v >= 0; v--) begin
      acc(1, 8'h00, v ^ 1);
      acc(1, 8'h18, v);
      repeat (12) @(posedge mclk);
      chk("main_sel", v ^ 1, main_sel_q);
      chk("clock_output_pin_sel", v, clock_output_pin_sel_q);
    end
    for (int k = 0; k < 4; k++) begin
      acc(1, 8'h34, md[k]);
      repeat (4) @(posedge mclk);
      chk("mode_out", 1, k == 0 ? &periph_clk_en_q : k == 1 ? flash_standby_q : flash_pd_q);
      acc(0, 8'h38, 0);
      chk("state", md[k] + 1, rdv[2:0]);
      {usb_irq, wdt_irq, wake_gpio[0], periph_irq} <= 4'h1 << k;
      repeat (8) @(posedge mclk);
      {usb_irq, wdt_irq, wake_gpio[0], periph_irq} <= 4'h0;
      acc(0, 8'h38, 0);
      chk("woke_state", 0, rdv[2:0]);
    end
    acc(1, 8'h1c, 5);
    acc(1, 8'h34, 3);
    repeat (4) @(posedge mclk);
    chk("power_off", 1, core_power_off_q);
    wakeup_pin <= 0;
    repeat (10) @(posedge mclk);
    wakeup_pin <= 1;
    repeat (10) @(posedge mclk);
    acc(0, 8'h1c, 0);
    chk("cpu_div", 1, rdv);
    acc(1, 8'h30, 4);
    acc(1, 8'h34, 3);
    repeat (4) @(posedge mclk);
    chk("locked_on", 0, core_power_off_q);
    end_sim;
  end
endmodule
bind clk_pwr_ctrl clk_pwr_ctrl_sva i_clk_pwr_ctrl_sva (.*);
